/* File: hdl/spc_defs.svh */
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// Register byte offsets
`define SPC_OFS_CTRL1   8'h00
`define SPC_OFS_BUF     8'h04
`define SPC_OFS_STAT    8'h08
`define SPC_OFS_RATE    8'h0C

// Control register field positions and reset values
`define SPC_BIT_WRITE_COLLISION_FLAG    7
`define SPC_BIT_OVF     6
`define SPC_BIT_EN      5
`define SPC_CTRL1_RST   8'h00
`define SPC_RATE_RST    8'h00

// Mode field codes
`define SPC_M_SPI_F4    4'h0
`define SPC_M_SPI_F16   4'h1
`define SPC_M_SPI_F64   4'h2
`define SPC_M_SPI_T2    4'h3
`define SPC_M_SPI_SS    4'h4
`define SPC_M_SPI_NOSS  4'h5
`define SPC_M_I2C_S7    4'h6
`define SPC_M_I2C_S10   4'h7
`define SPC_M_I2C_M     4'h8
`define SPC_M_SPI_BRG   4'hA
`define SPC_M_I2C_FW    4'hB
`define SPC_M_I2C_S7I   4'hE
`define SPC_M_I2C_S10I  4'hF

// Master clock half periods, in link clock cycles; four at the least in the fixed modes, so
// the peer's answer to a trailing edge clears the pin synchroniser in time
`define SPC_HALF_F4     10'h004
`define SPC_HALF_F16    10'h010
`define SPC_HALF_F64    10'h040
`define SPC_HALF_BRG1   10'h002

`endif

/* File: hdl/spc_pkg.sv */
`include "spc_defs.svh"

package spc_pkg;

  // Quasi-static port configuration
  typedef struct packed {
    logic       en;
    logic       clock_polarity_hold;
    logic [3:0] mode;
  } spc_cfg_t;

  // Driven side of a two-way pin
  typedef struct packed {
    logic o;
    logic oe_n;
  } spc_pin_t;

  // Link engine states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_ACK} spc_state_t;

  // Operating kinds selected by the mode field
  typedef enum logic [2:0] {
    KIND_SPI_M, KIND_SPI_S, KIND_I2C_S, KIND_I2C_M, KIND_NONE
  } spc_kind_t;

  // Mode field decode
  function automatic spc_kind_t spc_decode(input logic [3:0] m);
    case (m)
      `SPC_M_SPI_F4, `SPC_M_SPI_F16, `SPC_M_SPI_F64,
      `SPC_M_SPI_T2, `SPC_M_SPI_BRG:  spc_decode = KIND_SPI_M;
      `SPC_M_SPI_SS, `SPC_M_SPI_NOSS: spc_decode = KIND_SPI_S;
      `SPC_M_I2C_S7, `SPC_M_I2C_S10,
      `SPC_M_I2C_S7I, `SPC_M_I2C_S10I: spc_decode = KIND_I2C_S;
      `SPC_M_I2C_M, `SPC_M_I2C_FW:    spc_decode = KIND_I2C_M;
      default:                        spc_decode = KIND_NONE;
    endcase
  endfunction

endpackage

/* File: hdl/spc_sync.sv */
`timescale 1ns/100ps

module spc_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  logic [W-1:0] meta_r;

  // Width check
  if (W < 1) begin : g_chk
    $error("spc_sync: W must be at least 1");
  end

  // Two flops per bit; the first is read only by the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b0;
        q[i]      <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end

endmodule // spc_sync

/* File: hdl/spc_top.sv */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "spc_defs.svh"

// What this block does
// - A slave-mode buffer write while the previous word shifts sets the write collision flag, held until software clears it.
// - In SPI slave mode a byte completing while the buffer is still full sets the overflow flag and the new byte is dropped.
// - SPI master mode never sets the overflow flag; once set in slave mode it stays until software clears it.
// - In I2C a byte arriving while the buffer is full sets the overflow flag, held until software clears it.
// - The port enable hands the clock, data and select pins to the port in SPI and I2C slave modes; when clear the pins are released to I/O.
// - In SPI the serial clock idles high when the polarity bit is 1 and low when it is 0.
// - In I2C slave mode the polarity bit 1 releases the bus clock and 0 holds it low to stretch it.
// - The low four-bit mode field selects the operating mode of the port.
module spc_top #(
  parameter int BYTE_W = 8
) (
  // System clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB register port
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Link clock
  input  wire logic         link_clk,
  // Serial clock pin and data pin
  input  wire logic         clk_pin_i,
  output spc_pkg::spc_pin_t clk_pin,
  input  wire logic         dat_pin_i,
  output spc_pkg::spc_pin_t dat_pin,
  // SPI data in and select
  input  wire logic         sdi_pin_i,
  input  wire logic         ss_n_pin_i
);
  import spc_pkg::*;

  localparam logic [3:0] LAST_BIT = 4'(BYTE_W - 1);
  localparam logic [3:0] ALL_BITS = 4'(BYTE_W);

  // Width check
  if (BYTE_W != 8) begin : g_chk
    $error("spc_top: BYTE_W must be 8");
  end

  //////////////////////////////////////////////////////////////////////////
  // System clock side
  //////////////////////////////////////////////////////////////////////////

  logic              write_collision_flag_r;
  logic              ovf_r;
  spc_cfg_t          cfg_r;
  logic [7:0]        rate_r;
  logic [BYTE_W-1:0] rxbuf_r;
  logic              full_r;
  logic [BYTE_W-1:0] txdat_r;
  logic [BYTE_W-1:0] rx_word_r;
  logic              tx_tog_r;
  logic              rx_seen_r;
  logic [1:0]        evt_s_w;
  logic [31:0]       rdata_w;
  spc_kind_t         kind_p;

  // APB decode
  wire setup_w  = psel & ~penable;
  wire access_w = psel & penable & pready;
  wire wr_w     = access_w & pwrite;
  wire rd_w     = access_w & ~pwrite;
  wire hit_ctrl = (paddr == `SPC_OFS_CTRL1);
  wire hit_buf  = (paddr == `SPC_OFS_BUF);
  wire hit_stat = (paddr == `SPC_OFS_STAT);
  wire hit_rate = (paddr == `SPC_OFS_RATE);
  wire mapped_w = hit_ctrl | hit_buf | hit_stat | hit_rate;
  wire ctrl_wr  = wr_w & hit_ctrl;
  wire buf_wr   = wr_w & hit_buf;
  wire buf_rd   = rd_w & hit_buf;

  // Mode decode
  assign kind_p = spc_decode(cfg_r.mode);
  wire master_p = (kind_p == KIND_SPI_M);
  wire slave_p  = (kind_p == KIND_SPI_S) | (kind_p == KIND_I2C_S);

  // Transmit handshake and receive event
  wire busy_w   = tx_tog_r ^ evt_s_w[0];
  wire rx_evt   = evt_s_w[1] ^ rx_seen_r;
  wire room_w   = ~full_r | buf_rd | master_p;
  wire rx_load  = rx_evt & room_w;
  wire ovf_set  = rx_evt & ~room_w;
  wire write_collision_flag_set = buf_wr & busy_w & slave_p;
  wire tx_go    = buf_wr & ~busy_w & cfg_r.en;

  // Sticky flags; a hardware set beats a software clear of zero
  wire write_collision_flag_clr = ctrl_wr & ~pwdata[`SPC_BIT_WRITE_COLLISION_FLAG];
  wire ovf_clr  = ctrl_wr & ~pwdata[`SPC_BIT_OVF];
  wire write_collision_flag_nxt = write_collision_flag_set | (write_collision_flag_r & ~write_collision_flag_clr);
  wire ovf_nxt  = ovf_set | (ovf_r & ~ovf_clr);
  wire full_nxt = rx_load | (full_r & ~buf_rd);

  // Read data select
  assign rdata_w =
    hit_ctrl ? {24'h000000, write_collision_flag_r, ovf_r, cfg_r} :
    hit_buf  ? {{(32 - BYTE_W){1'b0}}, rxbuf_r} :
    hit_stat ? {30'h00000000, busy_w, full_r} :
    hit_rate ? {24'h000000, rate_r} : 32'h00000000;

  // APB answer, one access cycle with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & ~mapped_w;
      prdata  <= setup_w ? rdata_w : 32'h00000000;
    end
  end

  // Control, rate and flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision_flag_r <= 1'b0;
      ovf_r  <= 1'b0;
      cfg_r  <= spc_cfg_t'(6'(`SPC_CTRL1_RST));
      rate_r <= `SPC_RATE_RST;
    end else begin
      write_collision_flag_r <= write_collision_flag_nxt;
      ovf_r  <= ovf_nxt;
      if (ctrl_wr) begin
        cfg_r <= spc_cfg_t'(pwdata[`SPC_BIT_EN:0]);
      end
      if (wr_w & hit_rate) begin
        rate_r <= pwdata[7:0];
      end
    end
  end

  // Buffer: transmit word handed over, received word taken in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_r   <= '0;
      full_r    <= 1'b0;
      txdat_r   <= '0;
      tx_tog_r  <= 1'b0;
      rx_seen_r <= 1'b0;
    end else begin
      rx_seen_r <= evt_s_w[1];
      full_r    <= full_nxt;
      if (rx_load) begin
        rxbuf_r <= rx_word_r;
      end
      if (tx_go) begin
        txdat_r  <= pwdata[BYTE_W-1:0];
        tx_tog_r <= ~tx_tog_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Crossings
  //////////////////////////////////////////////////////////////////////////

  logic              lrst_w;
  logic [14:0]       cfg_s_w;
  logic [3:0]        pin_s_w;
  logic              rx_tog_r;
  logic              done_tog_r;

  // Link reset, asserted at once and released on the link clock
  spc_sync #(.W(1)) u_lrst (
    .clk   (link_clk),
    .rst_n (presetn),
    .d     (1'b1),
    .q     (lrst_w)
  );

  // Configuration, rate and transmit toggle into the link domain
  spc_sync #(.W(15)) u_cfg_sync (
    .clk   (link_clk),
    .rst_n (lrst_w),
    .d     ({cfg_r, rate_r, tx_tog_r}),
    .q     (cfg_s_w)
  );

  // Pins into the link domain
  spc_sync #(.W(4)) u_pin_sync (
    .clk   (link_clk),
    .rst_n (lrst_w),
    .d     ({clk_pin_i, dat_pin_i, sdi_pin_i, ss_n_pin_i}),
    .q     (pin_s_w)
  );

  // Receive and done toggles back to the system clock
  spc_sync #(.W(2)) u_evt_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({rx_tog_r, done_tog_r}),
    .q     (evt_s_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // Link clock side
  //////////////////////////////////////////////////////////////////////////

  spc_cfg_t          cfg_l;
  spc_kind_t         kind_l;
  spc_state_t        st_r;
  spc_pin_t          clk_nxt;
  spc_pin_t          dat_nxt;
  logic [BYTE_W-1:0] sh_r;
  logic [3:0]        cnt_r;
  logic [9:0]        div_r;
  logic [9:0]        half_w;
  logic              sck_gen_r;
  logic              sdo_r;
  logic              pend_r;
  logic              sck_d_r;
  logic              sda_d_r;
  logic              tx_seen_r;

  // Link side decode
  assign cfg_l   = spc_cfg_t'(cfg_s_w[14:9]);
  assign kind_l  = spc_decode(cfg_l.mode);
  wire [7:0] rate_l = cfg_s_w[8:1];
  wire tx_new    = cfg_s_w[0] ^ tx_seen_r;
  wire sck_s     = pin_s_w[3];
  wire sda_s     = pin_s_w[2];
  wire sdi_s     = pin_s_w[1];
  wire ss_n_s    = pin_s_w[0];
  wire spi_m     = cfg_l.en & (kind_l == KIND_SPI_M);
  wire spi_s     = cfg_l.en & (kind_l == KIND_SPI_S);
  wire i2c_s     = cfg_l.en & (kind_l == KIND_I2C_S);
  wire sel_s     = spi_s & (~ss_n_s | (cfg_l.mode == `SPC_M_SPI_NOSS));

  // Master half period from the mode field
  assign half_w =
    (cfg_l.mode == `SPC_M_SPI_F16) ? `SPC_HALF_F16 :
    (cfg_l.mode == `SPC_M_SPI_F64) ? `SPC_HALF_F64 :
    (cfg_l.mode == `SPC_M_SPI_BRG) ?
      10'({1'b0, rate_l, 1'b0}) + `SPC_HALF_BRG1 : `SPC_HALF_F4;

  // SPI clock edges: leading leaves idle level, trailing returns to it
  wire tick_m  = spi_m & (st_r == ST_RUN) & (div_r == 10'h001);
  wire chg_s   = sck_s ^ sck_d_r;
  wire lead_w  = spi_m ? tick_m & (sck_gen_r == cfg_l.clock_polarity_hold)
                       : sel_s & chg_s & (sck_d_r == cfg_l.clock_polarity_hold);
  wire trail_w = spi_m ? tick_m & (sck_gen_r != cfg_l.clock_polarity_hold)
                       : sel_s & chg_s & (sck_s == cfg_l.clock_polarity_hold);

  // I2C bus conditions
  wire scl_rise = sck_s & ~sck_d_r;
  wire scl_fall = ~sck_s & sck_d_r;
  wire start_w  = i2c_s & sck_s & sck_d_r & sda_d_r & ~sda_s;
  wire stop_w   = i2c_s & sck_s & sck_d_r & ~sda_d_r & sda_s;

  // Next pin drive; disabled port releases every pin
  assign clk_nxt = spi_m ? '{o: sck_gen_r, oe_n: 1'b0} :
                   i2c_s ? '{o: 1'b0, oe_n: cfg_l.clock_polarity_hold} :
                           '{o: 1'b1, oe_n: 1'b1};
  assign dat_nxt = spi_m ? '{o: sdo_r, oe_n: 1'b0} :
                   spi_s ? '{o: sdo_r, oe_n: ~sel_s} :
                   i2c_s ? '{o: 1'b0, oe_n: st_r != ST_ACK} :
                           '{o: 1'b1, oe_n: 1'b1};

  // Pin registers and edge history
  always_ff @(posedge link_clk or negedge lrst_w) begin
    if (!lrst_w) begin
      clk_pin   <= '{o: 1'b1, oe_n: 1'b1};
      dat_pin   <= '{o: 1'b1, oe_n: 1'b1};
      sck_d_r   <= 1'b0;
      sda_d_r   <= 1'b0;
      tx_seen_r <= 1'b0;
    end else begin
      clk_pin   <= clk_nxt;
      dat_pin   <= dat_nxt;
      sck_d_r   <= sck_s;
      sda_d_r   <= sda_s;
      tx_seen_r <= cfg_s_w[0];
    end
  end

  // Shift engine for SPI master, SPI slave and I2C slave
  always_ff @(posedge link_clk or negedge lrst_w) begin
    if (!lrst_w) begin
      st_r       <= ST_IDLE;
      sh_r       <= '0;
      cnt_r      <= 4'h0;
      div_r      <= 10'h000;
      sck_gen_r  <= 1'b0;
      sdo_r      <= 1'b1;
      pend_r     <= 1'b0;
      rx_tog_r   <= 1'b0;
      done_tog_r <= 1'b0;
      rx_word_r  <= '0;
    end else if (!cfg_l.en) begin
      st_r      <= ST_IDLE;
      cnt_r     <= 4'h0;
      sck_gen_r <= cfg_l.clock_polarity_hold;
      pend_r    <= 1'b0;
      if (pend_r | tx_new) begin
        done_tog_r <= ~done_tog_r;
      end
    end else if (tx_new) begin
      sh_r   <= txdat_r;
      sdo_r  <= txdat_r[BYTE_W-1];
      pend_r <= 1'b1;
    end else begin
      case (st_r)
        ST_IDLE: begin
          sck_gen_r <= cfg_l.clock_polarity_hold;
          cnt_r     <= 4'h0;
          div_r     <= half_w;
          if ((spi_m & pend_r) | sel_s | start_w) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (i2c_s) begin
            if (stop_w) begin
              st_r <= ST_IDLE;
            end else if (start_w) begin
              cnt_r <= 4'h0;
            end else if (scl_rise & (cnt_r != ALL_BITS)) begin
              sh_r  <= {sh_r[BYTE_W-2:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == LAST_BIT) begin
                rx_word_r <= {sh_r[BYTE_W-2:0], sda_s};
                rx_tog_r  <= ~rx_tog_r;
              end
            end else if (scl_fall & (cnt_r == ALL_BITS)) begin
              st_r <= ST_ACK;
            end
          end else if (spi_m | sel_s) begin
            if (tick_m) begin
              sck_gen_r <= ~sck_gen_r;
              div_r     <= half_w;
            end else if (spi_m) begin
              div_r <= div_r - 10'h001;
            end
            if (lead_w) begin
              sh_r  <= {sh_r[BYTE_W-2:0], sdi_s};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == LAST_BIT) begin
                rx_word_r <= {sh_r[BYTE_W-2:0], sdi_s};
                rx_tog_r  <= ~rx_tog_r;
              end
            end
            if (trail_w) begin
              sdo_r <= sh_r[BYTE_W-1];
              if (cnt_r == ALL_BITS) begin
                cnt_r <= 4'h0;
                if (spi_m) begin
                  st_r <= ST_IDLE;
                end
                if (pend_r) begin
                  pend_r     <= 1'b0;
                  done_tog_r <= ~done_tog_r;
                end
              end
            end
          end else begin
            st_r <= ST_IDLE;
          end
        end
        ST_ACK: begin
          if (!i2c_s | stop_w) begin
            st_r <= ST_IDLE;
          end else if (scl_fall) begin
            st_r  <= ST_RUN;
            cnt_r <= 4'h0;
            if (pend_r) begin
              pend_r     <= 1'b0;
              done_tog_r <= ~done_tog_r;
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  //////////////////////////////////////////////////////////////////////////

  a_write_collision_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_wr && busy_w && slave_p) |=> write_collision_flag_r ##1 write_collision_flag_r || $past(ctrl_wr))
    else $error("write collision flag not set or not held");

  a_ovf_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_evt && full_r && !buf_rd && kind_p == KIND_SPI_S)
      |=> ovf_r && $stable(rxbuf_r))
    else $error("SPI overflow not flagged or data not dropped");

  a_ovf_master: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ovf_r) |-> !$past(master_p))
    else $error("overflow flag rose in SPI master mode");

  a_ovf_i2c: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_evt && full_r && !buf_rd && kind_p == KIND_I2C_S)
      |=> ovf_r && $stable(rxbuf_r))
    else $error("I2C overflow not flagged");

  a_pins_off: assert property (@(posedge link_clk) disable iff (!lrst_w)
    !cfg_l.en |=> clk_pin.oe_n && dat_pin.oe_n)
    else $error("pins driven while port disabled");

  a_idle_pol: assert property (@(posedge link_clk) disable iff (!lrst_w)
    (spi_m && st_r == ST_IDLE) ##1 spi_m
      |=> clk_pin.o == $past(cfg_l.clock_polarity_hold, 2))
    else $error("SPI clock idle level differs from polarity");

  a_clk_hold: assert property (@(posedge link_clk) disable iff (!lrst_w)
    (i2c_s && !cfg_l.clock_polarity_hold) |=> !clk_pin.oe_n && !clk_pin.o)
    else $error("I2C clock not held low");

  a_mode_dec: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_r.mode == `SPC_M_I2C_M) |-> ##1 $past(kind_p) == KIND_I2C_M)
    else $error("mode field decoded wrongly");

  c_write_collision_flag: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(write_collision_flag_r));
  c_ovf: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(ovf_r));
  c_rx: cover property (@(posedge pclk) disable iff (!presetn)
    rx_load ##[1:200] buf_rd);
  c_ack: cover property (@(posedge link_clk) disable iff (!lrst_w)
    st_r == ST_ACK);

endmodule // spc_top

/* File: tb/spc_peer_model.sv */
`timescale 1ns/100ps

// Bus peer: SPI master or slave, or I2C master, on the serial pins
module spc_peer_model (
  // Pin drive of the port
  input  wire spc_pkg::spc_pin_t clk_pin,
  input  wire spc_pkg::spc_pin_t dat_pin,
  // Resolved wires and lines the peer drives
  output logic                   clk_w,
  output logic                   dat_w,
  output logic                   sdo,
  output logic                   ss_n
);
  import spc_pkg::*;
  logic       scl_d  = 1'b1;
  logic       sda_d  = 1'b1;
  logic       slv_on = 1'b0;
  logic [7:0] txs    = 8'h00;
  logic [7:0] rx     = 8'h00;
  logic       ack    = 1'b1;

  // Wired lines with pull-ups; a port that drives wins over the pull-up
  assign clk_w = (clk_pin.oe_n ? 1'b1 : clk_pin.o) & scl_d;
  assign dat_w = (dat_pin.oe_n ? 1'b1 : dat_pin.o) & sda_d;

  initial begin
    sdo  = 1'b0;
    ss_n = 1'b1;
  end

  // Slave role: capture on the leading edge, shift on the trailing one
  always @(posedge clk_w) if (slv_on) rx = {rx[6:0], dat_w};
  always @(negedge clk_w) if (slv_on) begin
    txs = {txs[6:0], ~txs[7]}; // Spent bits become a changing pattern
    sdo = txs[7];
  end

  // Load the byte the peer returns when the port is master
  task automatic arm(input logic [7:0] tx);
    slv_on = 1'b1;
    txs    = tx;
    sdo    = tx[7];
    rx     = 8'h00;
  endtask

  // Master role: clock idles low, only runs within the frame
  task automatic spi_xfer(input logic [7:0] tx);
    slv_on = 1'b0;
    ss_n   = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdo = tx[i];
      #200;
      scl_d = 1'b1;
      rx    = {rx[6:0], dat_w};
      #200;
      scl_d = 1'b0;
    end
    #200;
    ss_n = 1'b1;
    sdo  = ~sdo; // Released line shows the inverse of its last bit
  endtask

  // One I2C clock pulse; the data line is read while the clock is high
  task automatic i2c_bit(input logic b);
    sda_d = b;
    #320;
    scl_d = 1'b1;
    #320;
    ack   = dat_w;
    scl_d = 1'b0;
  endtask

  // START, eight bits MSB first, acknowledge slot, STOP
  task automatic i2c_send(input logic [7:0] d);
    sda_d = 1'b0;
    #320;
    scl_d = 1'b0;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i]);
    i2c_bit(1'b1);
    sda_d = 1'b0;
    #320;
    scl_d = 1'b1;
    #320;
    sda_d = 1'b1;
    #320;
  endtask
endmodule // spc_peer_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`include "spc_defs.svh"

// Self-checking bench for the serial port control block
module testbench;
  import spc_pkg::*;
  logic        pclk, link_clk, presetn;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  spc_pin_t    clk_pin, dat_pin;
  logic        clk_w, dat_w, sdo, ss_n;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cyc       = 0;

  spc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .clk_pin_i(clk_w), .clk_pin(clk_pin),
    .dat_pin_i(dat_w), .dat_pin(dat_pin), .sdi_pin_i(sdo),
    .ss_n_pin_i(ss_n));

  spc_peer_model peer (.clk_pin(clk_pin), .dat_pin(dat_pin),
    .clk_w(clk_w), .dat_w(dat_w), .sdo(sdo), .ss_n(ss_n));

  ////////////////////////////////////////////////////////////////////////
  // Clocks of unrelated phase, and the hang limit
  always #12.5 pclk = ~pclk;
  always #16 link_clk = ~link_clk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Report and verdict
  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare a register value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Compare a pin or flag level
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // APB transfer: setup, then access held until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // Poll the busy bit until the word has left, then let the byte land
  task automatic wait_idle;
    do begin
      apb(1'b0, `SPC_OFS_STAT, 32'h0);
    end while (rdat[1] !== 1'b0);
    repeat (8) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    pclk = 1'b0;
    link_clk = 1'b1;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`SPC_OFS_CTRL1, 32'h0);
    chkb(clk_pin.oe_n, 1'b1);
    wr(8'h10, 32'hFF);
    chkb(err, 1'b1);
    wr(`SPC_OFS_CTRL1, 32'hF0);
    rd(`SPC_OFS_CTRL1, 32'h30);
    repeat (8) @(posedge pclk);
    chkb(clk_pin.oe_n, 1'b0);
    chkb(clk_pin.o, 1'b1);
    wr(`SPC_OFS_CTRL1, 32'h0);
    // Master transfers in the three fixed rate modes
    for (int m = 0; m < 3; m++) begin
      wr(`SPC_OFS_CTRL1, 32'h20 + 32'(m));
      repeat (8) @(posedge pclk);
      chkb(clk_pin.o, 1'b0);
      // Arm only once the clock has settled at its idle level
      peer.arm(8'h3C ^ 8'(m));
      wr(`SPC_OFS_BUF, 32'hA5);
      wait_idle;
      rd(`SPC_OFS_BUF, {24'h0, 8'h3C ^ 8'(m)});
      chk({24'h0, peer.rx}, 32'hA5);
      wr(`SPC_OFS_CTRL1, 32'h0);
    end
    // Master mode overwrites an unread byte without an overflow
    wr(`SPC_OFS_CTRL1, 32'h20);
    repeat (8) @(posedge pclk);
    peer.arm(8'h5A);
    wr(`SPC_OFS_BUF, 32'h11);
    wait_idle;
    peer.arm(8'h96);
    wr(`SPC_OFS_BUF, 32'h22);
    wait_idle;
    rd(`SPC_OFS_CTRL1, 32'h20);
    rd(`SPC_OFS_BUF, 32'h96);
    wr(`SPC_OFS_CTRL1, 32'h0);
    repeat (8) @(posedge pclk);
    chkb(clk_pin.oe_n, 1'b1);
    // Slave mode with select: collision, then overflow held until cleared
    peer.scl_d = 1'b0;
    wr(`SPC_OFS_CTRL1, 32'h24);
    wr(`SPC_OFS_BUF, 32'h81);
    wr(`SPC_OFS_BUF, 32'h42);
    rd(`SPC_OFS_CTRL1, 32'hA4);
    peer.spi_xfer(8'hC3);
    chk({24'h0, peer.rx}, 32'h81);
    repeat (20) @(posedge pclk);
    rd(`SPC_OFS_BUF, 32'hC3);
    peer.spi_xfer(8'h0F);
    peer.spi_xfer(8'h77);
    repeat (20) @(posedge pclk);
    rd(`SPC_OFS_CTRL1, 32'hE4);
    rd(`SPC_OFS_BUF, 32'h0F);
    rd(`SPC_OFS_CTRL1, 32'hE4);
    wr(`SPC_OFS_CTRL1, 32'h24);
    rd(`SPC_OFS_CTRL1, 32'h24);
    wr(`SPC_OFS_CTRL1, 32'h0);
    // I2C slave: clock hold, release, then overflow on a second byte
    peer.scl_d = 1'b1;
    wr(`SPC_OFS_CTRL1, 32'h26);
    repeat (8) @(posedge pclk);
    chkb(clk_pin.oe_n, 1'b0);
    chkb(clk_pin.o, 1'b0);
    wr(`SPC_OFS_CTRL1, 32'h0);
    wr(`SPC_OFS_CTRL1, 32'h36);
    repeat (8) @(posedge pclk);
    chkb(clk_pin.oe_n, 1'b1);
    peer.i2c_send(8'h5A);
    chkb(peer.ack, 1'b0);
    peer.i2c_send(8'h99);
    repeat (20) @(posedge pclk);
    rd(`SPC_OFS_CTRL1, 32'h76);
    rd(`SPC_OFS_BUF, 32'h5A);
    // I2C master code: decoded, pins left released
    wr(`SPC_OFS_CTRL1, 32'h0);
    wr(`SPC_OFS_CTRL1, 32'h28);
    repeat (8) @(posedge pclk);
    chkb(clk_pin.oe_n, 1'b1);
    chkb(dat_pin.oe_n, 1'b1);
    rd(`SPC_OFS_CTRL1, 32'h28);
    stop_test;
  end
endmodule // testbench
